// file: bgc_gate_ctrl.sv
// Function
// - Low gate stays off until high gate tried or soft start passes 1.7V.
// - Twenty continuous high-gate cycles reset the PWM flip-flop at mid-cycle.
// - After that reset the low gate drives for the rest of the cycle.
// - Power, thermal or short fault enters idle for at least 200ms.
// - Idle pulls soft start and error amp low, both gates off.
// - Power or thermal fault must clear before any restart.
// - Short latch clears soon after set; restart every 200ms while short.
// - Feedback 250mV below active reference sets the short fault.
// - Short detection works in soft start, against the soft-start level.
// - Over-current trip starts a 220ms timeout with both gates off.
// - After over-current timeout restart; repeat timeout if still tripped.
// - Both external switches are never on together; switch node watched.
// - Bias or input supply lockout forces idle with gates off.
// - PWM period comes from a fixed 600kHz oscillator; timeout counts are in 20MHz clock cycles.
// - Low gate low whenever high gate high and during any fault.
`timescale 1ns/10ps
`default_nettype none
module bgc_gate_ctrl #(
    parameter int HICCUP_CYC = bgc_pkg::BGC_HICCUP_CYC,
    parameter int OC_CYC = bgc_pkg::BGC_OC_CYC,
    parameter int DUTY_LIMIT = bgc_pkg::BGC_DUTY_LIMIT
) (
    input wire logic mclk,
    input wire logic srst,
    input wire logic ramp_trip,
    input wire logic ss_above_1v7,
    input wire logic short_detect,
    input wire logic oc_trip,
    input wire logic thermal_fault,
    input wire logic vcc_lockout,
    input wire logic vin_lockout,
    input wire logic switch_node_high,
    output logic high_side_gate,
    output logic low_side_gate,
    output logic ss_discharge,
    output logic comp_pulldown,
    output logic fault_idle,
    output logic short_latched,
    output logic oc_hiccup
);
    import bgc_pkg::*;

    localparam logic [BGC_SLOT_W-1:0] LAST_SLOT = BGC_SLOT_W'(BGC_PERIOD_CYC - 1);
    localparam logic [BGC_SLOT_W-1:0] MID_SLOT = BGC_SLOT_W'(BGC_HALF_CYC);
    localparam logic [BGC_RUN_W-1:0] RUN_LAST = BGC_RUN_W'(DUTY_LIMIT - 1);

    bgc_fault_if flt ();

    logic [BGC_SLOT_W-1:0] slot;
    logic [BGC_RUN_W-1:0] hs_run;
    logic pwm_ff;
    logic low_allow;
    logic any_fault;
    logic block;
    logic duty_timeout;
    logic next_hs;
    logic next_ls;

    // =========================================================
    // Fault sequencer
    assign flt.thermal_fault = thermal_fault;
    assign flt.vcc_lockout = vcc_lockout;
    assign flt.vin_lockout = vin_lockout;
    assign flt.short_detect = short_detect;
    assign flt.oc_trip = oc_trip;

    bgc_fault_seq #(
        .HICCUP_CYC(HICCUP_CYC),
        .OC_CYC(OC_CYC)
    ) u_seq (
        .mclk(mclk),
        .srst(srst),
        .flt(flt)
    );

    // Raw faults also block the gates so they drop on the same edge the sequencer leaves BGC_RUN, not a cycle later
    assign any_fault = thermal_fault | vcc_lockout | vin_lockout | short_detect | oc_trip;
    assign block = flt.idle | any_fault;

    // =========================================================
    // Oscillator slot counter
    always_ff @(posedge mclk) begin
        if (srst) begin
            slot <= BGC_SLOT_RST;
        end else if (slot == LAST_SLOT) begin
            slot <= BGC_SLOT_RST;
        end else begin
            slot <= slot + 1'b1;
        end
    end

    // =========================================================
    // Continuous high-side cycle count
    always_ff @(posedge mclk) begin
        if (srst || flt.idle) begin
            hs_run <= BGC_RUN_RST;
        end else if (slot == LAST_SLOT) begin
            if (pwm_ff && hs_run != RUN_LAST) begin
                hs_run <= hs_run + 1'b1;
            end else begin
                hs_run <= BGC_RUN_RST;
            end
        end
    end

    assign duty_timeout = pwm_ff && (hs_run == RUN_LAST) && (slot == MID_SLOT);

    // =========================================================
    // PWM flip-flop
    always_ff @(posedge mclk) begin
        if (srst || block) begin
            pwm_ff <= 1'b0;
        end else if (slot == BGC_SLOT_RST) begin
            pwm_ff <= 1'b1;
        end else if (ramp_trip || duty_timeout) begin
            pwm_ff <= 1'b0;
        end
    end

    // =========================================================
    // Non-synchronous start-up permission
    always_ff @(posedge mclk) begin
        if (srst || flt.idle) begin
            low_allow <= 1'b0;
        end else if (high_side_gate || ss_above_1v7) begin
            low_allow <= 1'b1;
        end
    end

    // =========================================================
    // Gate drivers with break-before-make
    always_comb begin
        next_hs = pwm_ff && !block && !low_side_gate;
        next_ls = !pwm_ff && low_allow && !block && !high_side_gate
            && !switch_node_high;
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            high_side_gate <= 1'b0;
            low_side_gate <= 1'b0;
        end else begin
            high_side_gate <= next_hs;
            low_side_gate <= next_ls;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            ss_discharge <= 1'b0;
            comp_pulldown <= 1'b0;
            fault_idle <= 1'b0;
            short_latched <= 1'b0;
            oc_hiccup <= 1'b0;
        end else begin
            ss_discharge <= block;
            comp_pulldown <= block;
            fault_idle <= flt.idle;
            short_latched <= flt.short_latched;
            oc_hiccup <= flt.oc_hiccup;
        end
    end

    // =========================================================
    // Checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);

    sequence s_timeout_hit;
        pwm_ff && (hs_run == RUN_LAST) && (slot == MID_SLOT) && !block;
    endsequence

    sequence s_refresh_window;
        !pwm_ff [*8];
    endsequence

    sequence s_ramp_end;
        !pwm_ff ##1 !high_side_gate;
    endsequence

    a_gate_exclusive: assert property (!(high_side_gate && low_side_gate))
        else $error("both gates on");
    a_startup_hold: assert property (!low_allow |=> !low_side_gate)
        else $error("low gate on before start-up permission");
    a_startup_allow: assert property (!flt.idle && (high_side_gate || ss_above_1v7)
        |=> low_allow)
        else $error("start-up permission not granted");
    a_duty_reset: assert property (s_timeout_hit |=> !pwm_ff)
        else $error("duty timeout did not reset flip-flop");
    a_duty_count: assert property ((slot == LAST_SLOT) && pwm_ff && (hs_run != RUN_LAST)
        && !flt.idle |=> (hs_run == $past(hs_run) + 1'b1))
        else $error("continuous high cycle not counted");
    a_run_clear: assert property ((slot == LAST_SLOT) && !pwm_ff
        |=> (hs_run == BGC_RUN_RST))
        else $error("high cycle count not cleared");
    a_refresh_low: assert property (s_timeout_hit |=> s_refresh_window)
        else $error("flip-flop set again inside refresh window");
    a_refresh_gate: assert property (s_timeout_hit ##2 (low_allow && !block
        && !switch_node_high && !high_side_gate) |=> low_side_gate)
        else $error("low gate did not refresh bootstrap");
    a_fault_gates: assert property (block |=> !high_side_gate && !low_side_gate
        && ss_discharge && comp_pulldown)
        else $error("gates or pulldowns wrong in fault");
    a_idle_hold: assert property ($rose(fault_idle) |-> (!high_side_gate
        && !low_side_gate) [*4])
        else $error("gate on during idle hold");
    a_node_block: assert property (switch_node_high |=> !low_side_gate)
        else $error("low gate turned on with switch node high");
    a_ls_refused: assert property (high_side_gate |=> !low_side_gate)
        else $error("low gate follows high gate directly");
    a_hs_deadtime: assert property (low_side_gate |=> !high_side_gate)
        else $error("high gate follows low gate directly");
    a_period_wrap: assert property (slot == LAST_SLOT |=> slot == BGC_SLOT_RST
        ##1 slot == 6'h01)
        else $error("oscillator period wrong");
    a_pwm_set: assert property (slot == BGC_SLOT_RST && !block |=> pwm_ff)
        else $error("flip-flop not set at cycle start");
    a_ramp_reset: assert property (slot != BGC_SLOT_RST && ramp_trip && pwm_ff
        |=> s_ramp_end)
        else $error("ramp trip did not end high gate");
endmodule
`default_nettype wire

// file: bgc_pkg.sv
`default_nettype none
package bgc_pkg;
    // =========================================================
    // Timing
    localparam int BGC_CLK_HZ = 20000000;
    localparam int BGC_OSC_HZ = 600000;
    localparam int BGC_PERIOD_CYC = BGC_CLK_HZ / BGC_OSC_HZ;
    localparam int BGC_HALF_CYC = BGC_PERIOD_CYC / 2;
    localparam int BGC_DUTY_LIMIT = 20;
    localparam int BGC_HICCUP_MS = 200;
    localparam int BGC_OC_MS = 220;
    localparam int BGC_HICCUP_CYC = BGC_HICCUP_MS * (BGC_CLK_HZ / 1000);
    localparam int BGC_OC_CYC = BGC_OC_MS * (BGC_CLK_HZ / 1000);
    localparam int BGC_TIMER_W = 23;
    localparam int BGC_SLOT_W = 6;
    localparam int BGC_RUN_W = 5;

    // =========================================================
    // Reset values
    localparam logic [BGC_SLOT_W-1:0] BGC_SLOT_RST = 6'h00;
    localparam logic [BGC_RUN_W-1:0] BGC_RUN_RST = 5'h00;
    localparam logic [BGC_TIMER_W-1:0] BGC_TIMER_RST = 23'h00_0000;

    typedef enum logic [1:0] {
        BGC_RUN,
        BGC_HOLD,
        BGC_WAIT_CLEAR
    } bgc_state_t;
endpackage
`default_nettype wire

// file: bgc_fault_if.sv
`timescale 1ns/10ps
`default_nettype none
interface bgc_fault_if;
    logic thermal_fault;
    logic vcc_lockout;
    logic vin_lockout;
    logic short_detect;
    logic oc_trip;
    logic idle;
    logic short_latched;
    logic oc_hiccup;

    modport seq (
        input thermal_fault, vcc_lockout, vin_lockout, short_detect, oc_trip,
        output idle, short_latched, oc_hiccup
    );
    modport ctl (
        output thermal_fault, vcc_lockout, vin_lockout, short_detect, oc_trip,
        input idle, short_latched, oc_hiccup
    );
endinterface
`default_nettype wire

// file: bgc_fault_seq.sv
`timescale 1ns/10ps
`default_nettype none
module bgc_fault_seq #(
    parameter int HICCUP_CYC = bgc_pkg::BGC_HICCUP_CYC,
    parameter int OC_CYC = bgc_pkg::BGC_OC_CYC
) (
    input wire logic mclk,
    input wire logic srst,
    bgc_fault_if.seq flt
);
    import bgc_pkg::*;

    localparam logic [BGC_TIMER_W-1:0] HICCUP_LOAD = BGC_TIMER_W'(HICCUP_CYC - 1);
    localparam logic [BGC_TIMER_W-1:0] OC_LOAD = BGC_TIMER_W'(OC_CYC - 1);

    bgc_state_t state;
    logic [BGC_TIMER_W-1:0] timer;
    logic short_latch;
    logic oc_mode;
    logic power_fault;

    assign power_fault = flt.thermal_fault | flt.vcc_lockout | flt.vin_lockout;

    // =========================================================
    // Hiccup state machine
    always_ff @(posedge mclk) begin
        if (srst) begin
            state <= BGC_RUN;
            timer <= BGC_TIMER_RST;
            oc_mode <= 1'b0;
        end else begin
            case (state)
                BGC_RUN: begin
                    if (power_fault || short_latch || flt.short_detect) begin
                        state <= BGC_HOLD;
                        timer <= HICCUP_LOAD;
                        oc_mode <= 1'b0;
                    end else if (flt.oc_trip) begin
                        state <= BGC_HOLD;
                        timer <= OC_LOAD;
                        oc_mode <= 1'b1;
                    end
                end
                BGC_HOLD: begin
                    if (timer == BGC_TIMER_RST) begin
                        state <= power_fault ? BGC_WAIT_CLEAR : BGC_RUN;
                    end else begin
                        timer <= timer - 1'b1;
                    end
                end
                BGC_WAIT_CLEAR: begin
                    if (!power_fault) begin
                        state <= BGC_RUN;
                    end
                end
                default: begin
                    state <= BGC_RUN;
                end
            endcase
        end
    end

    // Short latch set only while running, dropped once the hold has begun
    always_ff @(posedge mclk) begin
        if (srst) begin
            short_latch <= 1'b0;
        end else begin
            short_latch <= (flt.short_detect && state == BGC_RUN)
                || (short_latch && state != BGC_HOLD);
        end
    end

    assign flt.idle = (state != BGC_RUN);
    assign flt.short_latched = short_latch;
    assign flt.oc_hiccup = oc_mode && (state == BGC_HOLD);

    // =========================================================
    // Checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);

    a_hiccup_entry: assert property ((state == BGC_RUN) && power_fault
        |=> (state == BGC_HOLD) && (timer == HICCUP_LOAD))
        else $error("hiccup hold not loaded");
    a_power_wait: assert property ((state == BGC_HOLD) && (timer == BGC_TIMER_RST)
        && power_fault |=> (state == BGC_WAIT_CLEAR) && flt.idle
        ##1 (flt.idle || !$past(power_fault)))
        else $error("restart with power fault present");
    a_short_clear: assert property ((state == BGC_HOLD) && short_latch
        |=> !short_latch)
        else $error("short latch not cleared in hold");
    a_oc_timeout: assert property ((state == BGC_RUN) && flt.oc_trip && !power_fault
        && !short_latch && !flt.short_detect
        |=> (state == BGC_HOLD) && (timer == OC_LOAD) && flt.oc_hiccup)
        else $error("over-current timeout not started");
    a_lockout_idle: assert property ((flt.vcc_lockout || flt.vin_lockout) && !flt.idle
        |=> flt.idle)
        else $error("lockout did not force idle");
endmodule
`default_nettype wire

// file: bgc_nfet_model.sv
`timescale 1ns/10ps
`default_nettype none
module bgc_nfet_model (
    input wire logic mclk,
    input wire logic high_side_gate,
    input wire logic low_side_gate,
    input wire logic [1:0] lag,
    output logic switch_node_high
);
    logic [1:0] hold_cnt = 2'h0;
    // =========================================================
    // Node stays up for lag cycles after the high switch opens
    always_ff @(posedge mclk) begin
        if (high_side_gate) begin
            hold_cnt <= lag;
        end else if (low_side_gate) begin
            hold_cnt <= 2'h0;
        end else if (hold_cnt != 2'h0) begin
            hold_cnt <= hold_cnt - 2'h1;
        end
    end
    assign switch_node_high = high_side_gate || (hold_cnt != 2'h0);
endmodule
`default_nettype wire

// file: tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
    import bgc_pkg::*;
    localparam int HC = 50;
    localparam int OC = 60;
    localparam int CUT = (BGC_DUTY_LIMIT - 1) * BGC_PERIOD_CYC + BGC_HALF_CYC;
    typedef struct {logic [2:0] v; int gap;} bgc_note_t;
    logic mclk = 1'b0;
    logic srst = 1'b1;
    logic ramp_trip = 1'b0;
    logic ss_above_1v7 = 1'b0;
    logic short_detect = 1'b0;
    logic oc_trip = 1'b0;
    logic thermal_fault = 1'b0;
    logic vcc_lockout = 1'b0;
    logic vin_lockout = 1'b0;
    logic [1:0] lag = 2'h0;
    logic track = 1'b0;
    logic sw, hs, ls, ss_dis, comp_pd, idle, short_latched, oc_hiccup;
    logic [2:0] prev = 3'h0;
    logic [2:0] v;
    logic node_q = 1'b0;
    logic short_q = 1'b0;
    logic [31:0] seed = 32'h0000_d996;
    bgc_note_t nt;
    bgc_note_t notes[$];
    int n_mismatch = 0;
    int samples_checked = 0;
    int cyc = 0;
    int last_chg = 0;
    int n_short = 0;

    always #25 mclk = ~mclk;

    bgc_gate_ctrl #(.HICCUP_CYC(HC), .OC_CYC(OC), .DUTY_LIMIT(BGC_DUTY_LIMIT)) bgc_gate_ctrl_i (
        .mclk(mclk), .srst(srst), .ramp_trip(ramp_trip), .ss_above_1v7(ss_above_1v7),
        .short_detect(short_detect), .oc_trip(oc_trip), .thermal_fault(thermal_fault),
        .vcc_lockout(vcc_lockout), .vin_lockout(vin_lockout), .switch_node_high(sw),
        .high_side_gate(hs), .low_side_gate(ls), .ss_discharge(ss_dis),
        .comp_pulldown(comp_pd), .fault_idle(idle), .short_latched(short_latched),
        .oc_hiccup(oc_hiccup)
    );
    bgc_nfet_model bgc_nfet_model_i (
        .mclk(mclk), .high_side_gate(hs), .low_side_gate(ls), .lag(lag),
        .switch_node_high(sw)
    );

    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge mclk);
        #2;
    endtask

    task automatic note(input logic [2:0] nv, input int gap);
        notes.push_back('{nv, gap});
    endtask

    task automatic drain;
        int t;
        t = 0;
        while (notes.size() != 0 && t < 1000) begin
            step(1);
            t++;
        end
        check(notes.size(), 0);
    endtask

    task automatic tally_and_finish;
        $display("Mismatches %0d, comparisons %0d", n_mismatch, samples_checked);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // =========================================================
    // Output watcher: gate/idle changes are matched against notes
    always @(posedge mclk) begin
        #1;
        cyc++;
        v = {hs, ls, idle};
        if (!srst) begin
            if (hs === 1'b1) check(ls, 1'b0);
            if (idle === 1'b1) check({hs, ls}, 2'b00);
            if (ls === 1'b1 && prev[1] === 1'b0) check(node_q, 1'b0);
            if (short_latched === 1'b1 && short_q === 1'b0) n_short++;
            if (track && v !== prev) begin
                if (notes.size() == 0) begin
                    check({29'h0, v}, 32'hffff_ffff);
                end else begin
                    nt = notes.pop_front();
                    check(v, nt.v);
                    if (nt.gap != 0) check(cyc - last_chg, nt.gap);
                end
            end
            if (v !== prev) last_chg = cyc;
        end
        prev = v;
        node_q = sw;
        short_q = short_latched;
        if (cyc > 6000) begin
            n_mismatch++;
            tally_and_finish();
        end
    end

    // =========================================================
    // Stimulus
    initial begin
        step(6);
        srst = 1'b0;
        track = 1'b1;
        note(3'b100, 0);
        note(3'b000, CUT);
        note(3'b010, 0);
        note(3'b000, 0);
        note(3'b100, 0);
        drain();
        for (int k = 0; k < 3; k++) begin
            note(3'b000, 0);
            note(3'b001, 1);
            note(3'b000, 0);
            note(3'b100, 0);
            step(2);
            {thermal_fault, vcc_lockout, vin_lockout} = 3'b100 >> k;
            step(70);
            check(idle, 1'b1);
            check({ss_dis, comp_pd}, 2'b11);
            step(10);
            {thermal_fault, vcc_lockout, vin_lockout} = 3'b000;
            drain();
            check({ss_dis, comp_pd}, 2'b00);
        end
        note(3'b000, 0);
        note(3'b001, 1);
        note(3'b000, HC);
        note(3'b001, 0);
        note(3'b000, HC);
        note(3'b100, 0);
        step(2);
        short_detect = 1'b1;
        step(60);
        check(idle, 1'b1);
        check(oc_hiccup, 1'b0);
        short_detect = 1'b0;
        drain();
        check(n_short, 2);
        note(3'b000, 0);
        note(3'b001, 1);
        note(3'b000, OC);
        note(3'b001, 0);
        note(3'b000, OC);
        note(3'b100, 0);
        step(2);
        oc_trip = 1'b1;
        step(30);
        check({oc_hiccup, ss_dis}, 2'b11);
        step(40);
        oc_trip = 1'b0;
        drain();
        check(oc_hiccup, 1'b0);
        track = 1'b0;
        for (int i = 0; i < 1500; i++) begin
            seed = xorshift(seed);
            ramp_trip = seed[0];
            ss_above_1v7 = seed[1];
            lag = seed[3:2];
            step(1);
        end
        tally_and_finish();
    end
endmodule
`default_nettype wire
